// >>> amx_bank.sv
// register bank of the 32-channel high level input multiplexer card
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module amx_bank
   import amx_pkg::*;
#(
   parameter logic [15:0] CONFIG_VALUE = AMX_CONFIG_DEFAULT,
   // identity value is arbitrary
   parameter logic [15:0] IDENT_VALUE = AMX_IDENT_DEFAULT
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [AMX_ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output amx_conv_req_s conv_o,
   input wire amx_conv_rsp_s conv_i,
   input wire logic open_detect_i,
   output logic [AMX_SEL_W-1:0] mux_chan_o,
   output logic mux_en_o,
   output logic full_scale_o
);

   amx_state_s s_reg;
   amx_state_s s_next;

   logic req_live;
   logic word2;
   logic [3:0] row;
   logic [3:0] page;
   logic [AMX_CH_W-1:0] ch;
   logic ch_fitted;
   logic [AMX_SEL_W-1:0] ch_sel;
   logic [2:0] ch_gain;
   logic in_data;
   logic in_zero;
   logic in_gain;
   logic [15:0] rd_word;
   logic in_card;
   logic [15:0] card_word;
   logic open_next;
   logic conv_start;
   amx_conv_req_s conv_load;
   logic gain_wr_ok;
   logic [AMX_NUM_CH-1:0] gain_wr;
   logic [AMX_NUM_CH-1:0][2:0] gain_new;
   logic force_full;
   logic [AMX_CONV_W-1:0] conv_word;
   genvar gi;

   assign req_live = cyc_i && stb_i && !s_reg.ack;
   assign word2 = adr_i[AMX_WORD_BIT];
   assign row = adr_i[AMX_ROW_MSB:AMX_ROW_LSB];
   assign page = adr_i[AMX_PAGE_MSB:AMX_PAGE_LSB];

   // three channel pages per group, 16 rows each; the last page holds the card words
   always_comb
   begin
      in_data = 1'b0;
      in_zero = 1'b0;
      in_gain = 1'b0;
      in_card = 1'b0;
      unique case (page) inside
         [AMX_PAGE_DATA_LO:AMX_PAGE_DATA_HI]:
         begin
            in_data = 1'b1;
         end
         [AMX_PAGE_ZERO_LO:AMX_PAGE_ZERO_HI]:
         begin
            in_zero = 1'b1;
         end
         [AMX_PAGE_GAIN_LO:AMX_PAGE_GAIN_HI]:
         begin
            in_gain = 1'b1;
         end
         AMX_PAGE_CARD:
         begin
            in_card = 1'b1;
         end
         default:
         begin
            // reserved pages decode to nothing and read zero
            in_card = 1'b0;
         end
      endcase
   end

   // channel index 0..47 from the low page bits and the row
   always_comb
   begin
      ch = '0;
      if (in_data || in_zero || in_gain)
      begin
         // pages of one group differ only in their low two bits
         ch = {page[1:0], row};
      end
   end

   assign ch_fitted = (ch < AMX_CH_W'(AMX_NUM_CH));
   assign ch_sel = ch[AMX_SEL_W-1:0];
   assign ch_gain = s_reg.gain[ch_sel];

   // a gain code read back in the low bits of a word
   function automatic logic [15:0] amx_gain_word(input logic [2:0] code);
      amx_gain_word = {13'h0000, code};
   endfunction : amx_gain_word

   // card page: configuration, status and identity words
   always_comb
   begin
      card_word = 16'h0000;
      if (in_card && !word2)
      begin
         unique case (row)
            AMX_ROW_CONFIG: card_word = CONFIG_VALUE;
            AMX_ROW_STATUS: card_word = AMX_STATUS_VALUE;
            AMX_ROW_IDENT: card_word = IDENT_VALUE;
            default: card_word = 16'h0000;
         endcase
      end
   end

   // immediate read answers; unfitted channels and holes read zero
   always_comb
   begin
      rd_word = 16'h0000;
      if (in_data || in_zero)
      begin
         if (word2 && ch_fitted)
         begin
            rd_word = amx_gain_word(ch_gain);
         end
      end
      else if (in_gain)
      begin
         if (!word2 && ch_fitted)
         begin
            rd_word = amx_gain_word(ch_gain);
         end
      end
      else if (in_card)
      begin
         rd_word = card_word;
      end
   end

   // open sense: three flops, a change is taken once the last two agree
   always_comb
   begin
      open_next = s_reg.open;
      if (s_reg.sync[1] == s_reg.sync[2])
      begin
         open_next = s_reg.sync[2];
      end
   end

   // a read of a fitted channel's first word starts a conversion;
   // the request then stands until done, so one reading is outstanding
   always_comb
   begin
      conv_start = 1'b0;
      conv_load = s_reg.conv;
      if (req_live && !we_i && (in_data || in_zero) && !word2 && ch_fitted)
      begin
         conv_start = 1'b1;
         conv_load.req = 1'b1;
         conv_load.zero = in_zero;
         conv_load.chan = ch_sel;
         conv_load.gain = ch_gain;
      end
   end

   // a gain write needs the low byte lane and a legal code
   always_comb
   begin
      gain_wr_ok = 1'b0;
      if (req_live && we_i && (s_reg.st == AMX_ST_IDLE))
      begin
         if (in_gain && !word2 && ch_fitted && sel_i[0])
         begin
            gain_wr_ok = (dat_i[2:0] <= AMX_GAIN_AUTO);
         end
      end
   end

   // one gain register per fitted channel; refused writes keep the old code
   generate
      for (gi = 0; gi < AMX_NUM_CH; gi++)
      begin : g_gain
         assign gain_wr[gi] = gain_wr_ok && (ch_sel == AMX_SEL_W'(gi));
         assign gain_new[gi] = gain_wr[gi] ? dat_i[2:0] : s_reg.gain[gi];
      end
   endgenerate

   // open input or overrange both end in the same full-scale reading;
   // a zero-reference conversion ignores the open sense
   always_comb
   begin
      force_full = 1'b0;
      if (s_reg.open && !s_reg.conv.zero)
      begin
         force_full = 1'b1;
      end
      if (conv_i.overrange)
      begin
         force_full = 1'b1;
      end
      conv_word = conv_i.data;
      if (force_full)
      begin
         conv_word = AMX_FULL_SCALE;
      end
   end

   always_comb
   begin
      s_next = s_reg;
      s_next.ack = 1'b0;
      s_next.gain = gain_new;
      s_next.sync = {s_reg.sync[1:0], open_detect_i};
      s_next.open = open_next;
      unique case (s_reg.st)
         AMX_ST_IDLE:
         begin
            if (req_live)
            begin
               s_next.dat = {16'h0000, rd_word};
               s_next.st = AMX_ST_ACK;
               s_next.ack = 1'b1;
               if (we_i)
               begin
                  // writes answer zero; a gain write lands through gain_new
                  s_next.dat = 32'h0000_0000;
               end
               else if (conv_start)
               begin
                  // hold the answer until the converter is done
                  s_next.st = AMX_ST_CONV;
                  s_next.ack = 1'b0;
                  s_next.conv = conv_load;
               end
            end
         end
         AMX_ST_CONV:
         begin
            // gain stage driven positive while the input is open
            s_next.full = s_reg.open && !s_reg.conv.zero;
            if (conv_i.done)
            begin
               s_next.conv.req = 1'b0;
               s_next.full = 1'b0;
               s_next.st = AMX_ST_ACK;
               s_next.ack = 1'b1;
               s_next.dat = {18'h0_0000, conv_word};
            end
         end
         AMX_ST_ACK:
         begin
            s_next.st = AMX_ST_IDLE;
         end
         default:
         begin
            s_next.st = AMX_ST_IDLE;
            s_next.conv.req = 1'b0;
            s_next.full = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_reg <= '0;
         s_reg.st <= AMX_ST_IDLE;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // every port comes straight from a flop, so no decode glitch reaches the pins
   always_comb
   begin
      ack_o = s_reg.ack;
      dat_o = s_reg.dat;
      conv_o = s_reg.conv;
      mux_chan_o = s_reg.conv.chan;
      mux_en_o = s_reg.conv.req;
      full_scale_o = s_reg.full;
   end

endmodule : amx_bank

// >>> amx_bank_props.sv
// port assertions of the multiplexer register bank
`timescale 1ns/1ps
module amx_bank_props
   import amx_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [AMX_ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire amx_conv_req_s conv_o,
   input wire amx_conv_rsp_s conv_i,
   input wire logic [AMX_SEL_W-1:0] mux_chan_o,
   input wire logic mux_en_o,
   input wire logic full_scale_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire rd = cyc_i && stb_i && !we_i && !ack_o;
   chk_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   chk_sel_follow: assert property (conv_o.req |-> mux_en_o && mux_chan_o == conv_o.chan)
      else $error("mux select differs from request");
   chk_gain_legal: assert property (conv_o.req |-> conv_o.gain <= 3'h4)
      else $error("illegal gain code sent");
   chk_req_hold: assert property (conv_o.req && !conv_i.done |=> $stable(conv_o))
      else $error("request changed before done");
   chk_done_ack: assert property (conv_o.req && conv_i.done |=> ack_o && !conv_o.req)
      else $error("no ack after done");
   chk_ovr_full: assert property (conv_o.req && conv_i.done && conv_i.overrange
      && !conv_o.zero |=> dat_o == 32'h0000_1fff)
      else $error("overrange not full scale");
   chk_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
      else $error("upper read bits set");
   chk_status_zero: assert property (rd && adr_i == 11'h7d0 |=> ack_o && dat_o == '0)
      else $error("status not zero");
   chk_unfit_zero: assert property (rd && adr_i[10:7] == AMX_PAGE_DATA_HI
      |=> ack_o && dat_o == '0 && !conv_o.req)
      else $error("unfitted channel not zero");
   chk_full_cause: assert property (full_scale_o |-> conv_o.req || $past(conv_o.req))
      else $error("full scale outside conversion");
   cover property (conv_o.req && conv_i.done && conv_i.overrange);
   cover property (full_scale_o);
   cover property (ack_o && we_i);
endmodule : amx_bank_props
bind amx_bank amx_bank_props props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .conv_o(conv_o), .conv_i(conv_i),
   .mux_chan_o(mux_chan_o), .mux_en_o(mux_en_o), .full_scale_o(full_scale_o));

// >>> amx_bank_tb.sv
// self-checking bench of the multiplexer register bank
`timescale 1ns/1ps
module amx_bank_tb;
   import amx_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, open_detect_i = 0, ovr = 0;
   logic [10:0] adr_i = '0;
   logic [3:0] sel_i = 4'hf, lat = 4'h1;
   logic [31:0] dat_i = '0, dat_o, r;
   logic ack_o, mux_en_o, full_scale_o;
   logic [4:0] mux_chan_o;
   logic [13:0] val = 14'h0123;
   logic full_seen = 0;
   logic [4:0] mux_seen = '0;
   amx_conv_req_s conv_o, seen;
   amx_conv_rsp_s conv_i;
   int miscompares = 0, cmp_count = 0;
   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) if (conv_o.req) seen <= conv_o;
   always @(posedge clk_i) if (full_scale_o) full_seen <= 1;
   always @(posedge clk_i) if (mux_en_o) mux_seen <= mux_chan_o;
   amx_bank DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .conv_o(conv_o),
      .conv_i(conv_i), .open_detect_i(open_detect_i), .mux_chan_o(mux_chan_o),
      .mux_en_o(mux_en_o), .full_scale_o(full_scale_o));
   amx_conv_model conv (.clk_i(clk_i), .rst_i(rst_i), .req_i(conv_o), .lat_i(lat), .ovr_i(ovr),
      .val_i(val), .rsp_o(conv_i));
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [10:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      q = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
      @(posedge clk_i);
      if (n >= 50)
      begin
         miscompares++;
         end_of_test;
      end
   endtask : wb
   task automatic t_gain;
      for (int g = 0; g < 5; g++)
      begin
         wb(1, 11'h600, 32'(g), r);
         wb(0, 11'h600, 0, r);
         chk("gain ch1", 32'(g), r);
      end
      wb(1, 11'h600, 5, r);
      wb(0, 11'h004, 0, r);
      chk("gain after code 5", 4, r);
      wb(1, 11'h6f8, 3, r);
      wb(1, 11'h700, 2, r);
      wb(0, 11'h700, 0, r);
      chk("gain ch33", 0, r);
      $display("gain test done");
   endtask : t_gain
   task automatic t_conv;
      lat <= 4'h6;
      val <= 14'h2abc;
      wb(0, 11'h0f8, 0, r);
      chk("reading ch32", 32'h0000_2abc, r);
      chk("gain to converter", 3, 32'(seen.gain));
      chk("selected channel", 31, 32'(seen.chan));
      chk("mux channel", 31, 32'(mux_seen));
      lat <= 4'h0;
      wb(0, 11'h4f8, 0, r);
      chk("zero ch32", 32'h0000_2abc, r);
      chk("zero flag", 1, 32'(seen.zero));
      wb(0, 11'h0fc, 0, r);
      chk("gain word ch32", 3, r);
      $display("conversion test done");
   endtask : t_conv
   task automatic t_full;
      ovr <= 1;
      wb(0, 11'h000, 0, r);
      chk("overrange", 32'h0000_1fff, r);
      chk("no drive on overrange", 0, 32'(full_seen));
      ovr <= 0;
      open_detect_i <= 1;
      lat <= 4'h8;
      wb(0, 11'h000, 0, r);
      chk("open input", 32'h0000_1fff, r);
      chk("gain stage drive", 1, 32'(full_seen));
      open_detect_i <= 0;
      $display("full scale test done");
   endtask : t_full
   task automatic t_card;
      wb(0, 11'h7d0, 0, r);
      chk("status", 0, r);
      wb(0, 11'h200, 0, r);
      chk("unmapped", 0, r);
      wb(0, 11'h100, 0, r);
      chk("reading ch33", 0, r);
      $display("card test done");
   endtask : t_card
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      t_gain;
      t_conv;
      t_full;
      t_card;
      end_of_test;
   end
endmodule : amx_bank_tb

// >>> amx_conv_model.sv
// converter card model: answers each request lat_i+1 cycles after it appears
`timescale 1ns/1ps
module amx_conv_model
   import amx_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire amx_conv_req_s req_i,
   input wire logic [3:0] lat_i,
   input wire logic ovr_i,
   input wire logic [13:0] val_i,
   output amx_conv_rsp_s rsp_o
);
   logic [3:0] cnt;
   // outside a done pulse the word toggles so a stale read shows
   always @(posedge clk_i)
   begin
      rsp_o <= {2'b00, ~rsp_o.data};
      if (rst_i)
      begin
         cnt <= '0;
         rsp_o <= '0;
      end
      else if (req_i.req && !rsp_o.done)
      begin
         cnt <= cnt + 4'h1;
         if (cnt == lat_i)
         begin
            cnt <= '0;
            rsp_o <= {1'b1, ovr_i, val_i};
         end
      end
   end
endmodule : amx_conv_model

// >>> amx_pkg.sv
// shared constants and types of the analog multiplexer register bank
package amx_pkg;

   // channel counts
   localparam int AMX_NUM_CH = 32;
   localparam int AMX_MAP_CH = 48;
   localparam int AMX_CH_W = 6;
   localparam int AMX_SEL_W = 5;

   // converter word
   localparam int AMX_CONV_W = 14;
   localparam logic [13:0] AMX_FULL_SCALE = 14'h1fff;

   // bus geometry: byte address = ((page-1)*32 + (row-1)*2 + (word-1))*4
   localparam int AMX_ADR_W = 11;
   localparam int AMX_WORD_BIT = 2;
   localparam int AMX_ROW_LSB = 3;
   localparam int AMX_ROW_MSB = 6;
   localparam int AMX_PAGE_LSB = 7;
   localparam int AMX_PAGE_MSB = 10;

   // page indices, counted from zero
   localparam logic [3:0] AMX_PAGE_DATA_LO = 4'h0;
   localparam logic [3:0] AMX_PAGE_DATA_HI = 4'h2;
   localparam logic [3:0] AMX_PAGE_ZERO_LO = 4'h8;
   localparam logic [3:0] AMX_PAGE_ZERO_HI = 4'ha;
   localparam logic [3:0] AMX_PAGE_GAIN_LO = 4'hc;
   localparam logic [3:0] AMX_PAGE_GAIN_HI = 4'he;
   localparam logic [3:0] AMX_PAGE_CARD = 4'hf;

   // rows of the card page, counted from zero
   localparam logic [3:0] AMX_ROW_CONFIG = 4'h8;
   localparam logic [3:0] AMX_ROW_STATUS = 4'ha;
   localparam logic [3:0] AMX_ROW_IDENT = 4'hc;

   // register values
   localparam logic [15:0] AMX_STATUS_VALUE = 16'h0000;
   localparam logic [15:0] AMX_CONFIG_DEFAULT = 16'h0018;
   localparam logic [15:0] AMX_IDENT_DEFAULT = 16'h00a5;

   // gain codes
   typedef enum logic [2:0] {
      AMX_GAIN_X1 = 3'h0,
      AMX_GAIN_X2 = 3'h1,
      AMX_GAIN_X4 = 3'h2,
      AMX_GAIN_X8 = 3'h3,
      AMX_GAIN_AUTO = 3'h4
   } amx_gain_e;

   typedef enum logic [2:0] {
      AMX_ST_IDLE = 3'b001,
      AMX_ST_CONV = 3'b010,
      AMX_ST_ACK = 3'b100
   } amx_state_e;

   // request to the converter card
   typedef struct packed {
      logic req;
      logic zero;
      logic [AMX_SEL_W-1:0] chan;
      logic [2:0] gain;
   } amx_conv_req_s;

   // answer from the converter card
   typedef struct packed {
      logic done;
      logic overrange;
      logic [AMX_CONV_W-1:0] data;
   } amx_conv_rsp_s;

   // whole state of the bank
   typedef struct packed {
      amx_state_e st;
      logic ack;
      logic [31:0] dat;
      logic [AMX_NUM_CH-1:0][2:0] gain;
      logic [2:0] sync;
      logic open;
      amx_conv_req_s conv;
      logic full;
   } amx_state_s;

endpackage : amx_pkg
